// ==== bench/t8pwm_asserts.sv ====
// Port checker for the PWM timer
`timescale 1ns/1ps
module t8pwm_asserts #(parameter bit RES_SEVEN = 1'b0) (
  input wire logic I_CLK_SYS, I_SYS_RST, I_CE, I_WR, I_RD, O_PWM,
  input wire logic [1:0] I_ADDR,
  input wire logic [7:0] I_WDATA, O_RDATA
);
  logic [7:0] m [4];
  logic [1:0] ok;
  int cnt, tick, per;
  logic stp, f8, f6;
  // Expected timing from mirrored register writes
  assign tick = (1 << (2 * m[2][6:5])) * (m[2][4:0] + 1);
  assign per = tick * (m[2][7] ? (RES_SEVEN ? 128 : 64) : 256);
  assign stp = m[0][7:4] == 4'h0;
  assign f8 = m[0][1] && !m[2][7] && m[1] == 8'hff;
  assign f6 = m[0][1] && m[2][7] && !RES_SEVEN && m[1] == 8'h3f;
  // Two rises without a write, since prescaler phase is unknown after one
  always_ff @(posedge I_CLK_SYS) begin
    if (I_WR && I_CE) m[I_ADDR] <= I_WDATA;
    if (I_SYS_RST) m <= '{default: 8'h00};
    ok <= (I_SYS_RST || I_WR || !I_CE) ? 2'h0 : ok + 2'($rose(O_PWM) && ok != 2'h2);
    cnt <= $rose(O_PWM) ? 1 : cnt + 1;
  end
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_SYS_RST);
  sequence s_rise; $rose(O_PWM) && ok == 2'h2 && m[0] == 8'h12; endsequence
  sequence s_fall; $fell(O_PWM) && ok == 2'h2 && m[0] == 8'h12; endsequence
  a_period_len: assert property (s_rise |-> cnt == per)
    else $error("period");
  a_high_len: assert property (s_fall |-> cnt == tick * (m[1] + 1))
    else $error("high time");
  a_full_eight: assert property ($fell(O_PWM) |-> !(f8 && $past(f8)))
    else $error("full duty");
  a_full_six: assert property ($fell(O_PWM) |-> !(f6 && $past(f6)))
    else $error("full duty");
  a_rdata_idle: assert property ($past(I_CE && !I_RD) |-> O_RDATA == 8'h00)
    else $error("rdata idle");
  a_reg_readback: assert property ($past(I_CE && I_RD && I_ADDR != 2'h3)
    |-> O_RDATA == $past(m[I_ADDR])) else $error("readback");
  a_ce_freeze: assert property (!$past(I_CE) |-> $stable(O_PWM))
    else $error("freeze");
  a_stop_hold: assert property (stp && $past(stp, 6) && !$past(I_WR)
    && !$past(I_WR, 2) |-> $stable(O_PWM)) else $error("stopped source");
endmodule
bind t8pwm_top t8pwm_asserts #(.RES_SEVEN(RES_SEVEN)) u_chk (.I_CLK_SYS(I_CLK_SYS),
  .I_SYS_RST(I_SYS_RST), .I_CE(I_CE), .I_WR(I_WR), .I_RD(I_RD), .O_PWM(O_PWM),
  .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .O_RDATA(O_RDATA));

// ==== bench/t8pwm_load.sv ====
// External load on the PWM pin, counting cycles it is driven high
`timescale 1ns/1ps
module t8pwm_load (
  input wire logic i_clk, i_clr, i_pin,
  output int o_high
);
  // Clear wins, so a window starts on a known edge
  always_ff @(posedge i_clk) o_high <= i_clr ? 0 : o_high + int'(i_pin);
endmodule

// ==== bench/t8pwm_top_tb.sv ====
// Bench for the PWM timer: register port and pin duty windows
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("Error %s expected %0d seen %0d", n, e, g); end end
module t8pwm_top_tb;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, wr = 1'b0, rd = 1'b0, clr = 1'b0, pwm;
  logic [1:0] addr = 2'h0, n = 2'h0;
  logic [7:0] wdata = 8'h00, rdata, v;
  logic [13:0] src = 14'h0000;
  int high, fail_count = 0, total_checks = 0;
  // Rows: control, scale, bound, period clocks, high clocks
  int tab [8][5] = '{'{8'h12, 8'h00, 8'h7f, 256, 128}, '{8'h12, 8'h21, 8'h7f, 2048, 1024},
    '{8'h12, 8'h40, 8'h03, 4096, 64}, '{8'h12, 8'h00, 8'hff, 256, 256},
    '{8'h12, 8'h80, 8'h1f, 64, 32}, '{8'h12, 8'he0, 8'h00, 4096, 64},
    '{8'h12, 8'h80, 8'h3f, 64, 64}, '{8'h22, 8'h80, 8'h1f, 256, 128}};
  t8pwm_top #(.RES_SEVEN(1'b0)) dut (.I_CLK_SYS(clk), .I_SYS_RST(rst), .I_CE(ce),
    .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .I_SRC(src),
    .O_RDATA(rdata), .O_PWM(pwm));
  t8pwm_load u_load (.i_clk(clk), .i_clr(clr), .i_pin(pwm), .o_high(high));
  always #2 clk = ~clk;
  // External tick source rising every fourth clock
  always @(posedge clk) begin
    n <= n + 2'h1;
    src <= {14{n[1]}};
  end
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    {wr, addr, wdata} <= {1'b1, a, d};
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    {rd, addr} <= {1'b1, a};
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 4; a++) begin
      rd_reg(2'(a), v);
      `CHK("reset reg", 8'h00, v)
    end
    // Stopped source leaves the written count alone
    wr_reg(2'h3, 8'h2a);
    rd_reg(2'h3, v);
    `CHK("counter", 8'h2a, v)
    foreach (tab[i]) begin
      v = 8'hff;
      // Bound changes only at a zero count; a read every third cycle so none is missed
      for (int k = 0; v !== 8'h00; k++) begin
        // Three-cycle poll spacing is coprime to every period, so zero is not skipped
        if (i > 0) begin rd_reg(2'h3, v); @(posedge clk); end else v = 8'h00;
        if (k == 3000) begin fail_count++; end_of_test(); end
      end
      // Table columns are control, scale, bound; the addresses are 0, 2, 1
      wr_reg(2'h0, 8'(tab[i][0]));
      wr_reg(2'h2, 8'(tab[i][1]));
      wr_reg(2'h1, 8'(tab[i][2]));
      wr_reg(2'h3, 8'h00);
      rd_reg(2'h1, v);
      `CHK("bound", 8'(tab[i][2]), v)
      repeat (tab[i][3]) @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (tab[i][3]) @(posedge clk);
      #1 `CHK("pin high", tab[i][4], high)
      $display("test %0d done", i);
    end
    // Strobes are ignored while the enable is low
    ce <= 1'b0;
    wr_reg(2'h1, 8'h55);
    ce <= 1'b1;
    rd_reg(2'h1, v);
    `CHK("bound", 8'h1f, v)
    end_of_test();
  end
endmodule

// ==== pkg/t8pwm_pkg.sv ====
// Shared constants and types for the eight-bit PWM timer
// Functional notes
// - 8-bit period is 256 times prescale times scaler plus one source clocks.
// - 8-bit output is high for bound plus one counts out of 256.
// - Bound 255 in 8-bit mode holds the output high permanently.
// - Scale bits 6 to 5 divide the source clock by 1, 4, 16 or 64.
// - Scale bits 4 to 0 further divide the prescaled clock by value plus one.
// - The full eight-bit bound register is the duty value.
// - Control bits 7 to 4 pick the clock source.
// - Control bit 1 set and scale bit 7 clear selects 8-bit PWM.
// - Control bit 1 set and scale bit 7 set selects reduced resolution.
// - A build option picks 6-bit or 7-bit reduced range.
// - 6-bit mode has period 64 ticks, high for bound plus one.
// - 7-bit mode has period 128 ticks, high for bound plus one.
// - 6-bit mode with bound 63 holds the output high.
// - Counter counts up, is readable and writable, wraps at its top.
package t8pwm_pkg;
  localparam logic [1:0] ADDR_CONTROL = 2'h0;
  localparam logic [1:0] ADDR_BOUND = 2'h1;
  localparam logic [1:0] ADDR_SCALE = 2'h2;
  localparam logic [1:0] ADDR_COUNTER = 2'h3;
  localparam logic [7:0] RESET_CONTROL = 8'h00;
  localparam logic [7:0] RESET_BOUND = 8'h00;
  localparam logic [7:0] RESET_SCALE = 8'h00;
  localparam int CTL_SRC_MSB = 7;
  localparam int CTL_SRC_LSB = 4;
  localparam int CTL_PWM_BIT = 1;
  localparam int SCL_LOWRES_BIT = 7;
  localparam int SCL_PRE_MSB = 6;
  localparam int SCL_PRE_LSB = 5;
  localparam int SCL_DIV_MSB = 4;
  localparam int SCL_DIV_LSB = 0;
  localparam logic [7:0] TOP_8BIT = 8'hff;
  localparam logic [7:0] TOP_7BIT = 8'h7f;
  localparam logic [7:0] TOP_6BIT = 8'h3f;
  localparam logic [5:0] PRE_TOP_1 = 6'h00;
  localparam logic [5:0] PRE_TOP_4 = 6'h03;
  localparam logic [5:0] PRE_TOP_16 = 6'h0f;
  localparam logic [5:0] PRE_TOP_64 = 6'h3f;
  localparam logic [3:0] SRC_STOP = 4'h0;
  localparam logic [3:0] SRC_SYS = 4'h1;
  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } t8pwm_bus_s;
endpackage

// ==== rtl/t8pwm_top.sv ====
// Eight-bit PWM timer with register port and selectable tick source
`timescale 1ns/1ps
module t8pwm_top #(
  parameter bit RES_SEVEN = 1'b0
) (
  input wire logic I_CLK_SYS,
  input wire logic I_SYS_RST,
  input wire logic I_CE,
  input wire logic [1:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [13:0] I_SRC,
  output logic [7:0] O_RDATA,
  output logic O_PWM
);
  t8pwm_pkg::t8pwm_bus_s bus;
  assign bus = '{addr: I_ADDR, wdata: I_WDATA, wr: I_WR, rd: I_RD};

  logic [7:0] timer_control, next_timer_control;
  logic [7:0] period_bound, next_period_bound;
  logic [7:0] timer_scale, next_timer_scale;
  logic [7:0] counter_value, next_counter_value;
  logic [5:0] pre_cnt, next_pre_cnt;
  logic [4:0] div_cnt, next_div_cnt;
  logic [7:0] rdata, next_rdata;
  logic pwm, next_pwm;
  logic [13:0] s1, s2, s3;
  logic src_prev, next_src_prev;
  logic src_lvl, src_tick;
  logic [5:0] pre_top;
  logic [7:0] top;
  logic pwm_mode;

  // Three-stage synchronisers, one per external source; stage 1 feeds only stage 2
  genvar g;
  generate
    for (g = 0; g < 14; g++) begin : g_sync
      always_ff @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) begin
          s1[g] <= 1'b0;
          s2[g] <= 1'b0;
          s3[g] <= 1'b0;
        end else if (I_CE) begin
          s1[g] <= I_SRC[g];
          s2[g] <= s1[g];
          s3[g] <= s2[g];
        end
      end
    end
  endgenerate

  // Source select; a level counts only once stages two and three agree
  always_comb begin
    src_lvl = src_prev;
    src_tick = 1'b0;
    unique case (timer_control[t8pwm_pkg::CTL_SRC_MSB:t8pwm_pkg::CTL_SRC_LSB])
      t8pwm_pkg::SRC_STOP: src_tick = 1'b0;
      t8pwm_pkg::SRC_SYS: src_tick = 1'b1;
      default: begin
        if (s2[timer_control[7:4] - 4'h2] == s3[timer_control[7:4] - 4'h2]) begin
          src_lvl = s3[timer_control[7:4] - 4'h2];
        end
        src_tick = src_lvl & ~src_prev;
      end
    endcase
    next_src_prev = src_lvl;
  end

  // Prescale and resolution decode
  always_comb begin
    unique case (timer_scale[t8pwm_pkg::SCL_PRE_MSB:t8pwm_pkg::SCL_PRE_LSB])
      2'h0: pre_top = t8pwm_pkg::PRE_TOP_1;
      2'h1: pre_top = t8pwm_pkg::PRE_TOP_4;
      2'h2: pre_top = t8pwm_pkg::PRE_TOP_16;
      default: pre_top = t8pwm_pkg::PRE_TOP_64;
    endcase
    pwm_mode = timer_control[t8pwm_pkg::CTL_PWM_BIT];
    if (pwm_mode && timer_scale[t8pwm_pkg::SCL_LOWRES_BIT]) begin
      top = RES_SEVEN ? t8pwm_pkg::TOP_7BIT : t8pwm_pkg::TOP_6BIT;
    end else if (pwm_mode) begin
      top = t8pwm_pkg::TOP_8BIT;
    end else begin
      top = period_bound;
    end
  end

  // Register file, dividers, counter and output next values
  always_comb begin
    next_timer_control = timer_control;
    next_period_bound = period_bound;
    next_timer_scale = timer_scale;
    next_counter_value = counter_value;
    next_pre_cnt = pre_cnt;
    next_div_cnt = div_cnt;
    next_rdata = 8'h00;
    next_pwm = pwm;
    if (src_tick) begin
      if (pre_cnt >= pre_top) begin
        next_pre_cnt = 6'h00;
        if (div_cnt >= timer_scale[t8pwm_pkg::SCL_DIV_MSB:t8pwm_pkg::SCL_DIV_LSB]) begin
          next_div_cnt = 5'h00;
          // Up count only, wrap to zero at the top
          next_counter_value = (counter_value >= top) ? 8'h00 : counter_value + 8'h01;
        end else begin
          next_div_cnt = div_cnt + 5'h01;
        end
      end else begin
        next_pre_cnt = pre_cnt + 6'h01;
      end
    end
    // Bound compare is never latched mid-period; software keeps updates at zero
    if (pwm_mode) begin
      next_pwm = (next_counter_value <= period_bound);
    end else if (src_tick && next_counter_value == 8'h00 && counter_value != 8'h00) begin
      next_pwm = ~pwm;
    end
    if (bus.wr) begin
      unique case (bus.addr)
        t8pwm_pkg::ADDR_CONTROL: next_timer_control = bus.wdata;
        t8pwm_pkg::ADDR_BOUND: next_period_bound = bus.wdata;
        t8pwm_pkg::ADDR_SCALE: next_timer_scale = bus.wdata;
        t8pwm_pkg::ADDR_COUNTER: next_counter_value = bus.wdata;
      endcase
    end
    if (bus.rd) begin
      unique case (bus.addr)
        t8pwm_pkg::ADDR_CONTROL: next_rdata = timer_control;
        t8pwm_pkg::ADDR_BOUND: next_rdata = period_bound;
        t8pwm_pkg::ADDR_SCALE: next_rdata = timer_scale;
        t8pwm_pkg::ADDR_COUNTER: next_rdata = counter_value;
      endcase
    end
  end

  // State registers; clock enable freezes everything
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      timer_control <= t8pwm_pkg::RESET_CONTROL;
      period_bound <= t8pwm_pkg::RESET_BOUND;
      timer_scale <= t8pwm_pkg::RESET_SCALE;
      counter_value <= 8'h00;
      pre_cnt <= 6'h00;
      div_cnt <= 5'h00;
      rdata <= 8'h00;
      pwm <= 1'b0;
      src_prev <= 1'b0;
    end else if (I_CE) begin
      timer_control <= next_timer_control;
      period_bound <= next_period_bound;
      timer_scale <= next_timer_scale;
      counter_value <= next_counter_value;
      pre_cnt <= next_pre_cnt;
      div_cnt <= next_div_cnt;
      rdata <= next_rdata;
      pwm <= next_pwm;
      src_prev <= next_src_prev;
    end
  end

  assign O_RDATA = rdata;
  assign O_PWM = pwm; // inversion and pairing done outside
endmodule
